/* File: verilog/serial_port_service_unit.sv */
// Serial port service unit: coded functions over Wishbone, async serial link, ring buffer.
// Assumes one 100 MHz clock; link pins are asynchronous and are synchronised here.
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "serial_port_regs.svh"
`default_nettype none
module serial_port_service_unit #(
  parameter int CLK_HZ = `CLK_HZ
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial link.
  input wire logic rxd_i,
  input wire logic cd_i,
  input wire logic dsr_i,
  input wire logic cts_i,
  output logic txd_o,
  output logic dtr_o,
  output logic rts_o,
  output logic power_o,
  output logic rx_enable_o
);
  import serial_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic rxd_s, cd_s, dsr_s, cts_s;
  logic req, wr_cmd;
  logic [31:0] cfg_r, opt_r, result_r;
  logic open_r;
  logic [7:0] rate_r, bits_r, par_r, stop_r, opts_r;
  logic [6:0] len_r;
  logic [7:0] buf_mem [0:`BUF_DEPTH-1];
  logic [5:0] rd_ptr_r, wr_ptr_r;
  logic [6:0] count_r;
  logic full, avail;
  logic ovf_r, par_err_r, ovr_r, frm_err_r;
  logic [7:0] status;
  logic params_ok, rate_ok;
  logic [7:0] fn;
  logic do_pop, push;
  logic hold_v_r;
  logic [7:0] hold_r;
  logic tx_ready;

  assign {rxd_s, cd_s, dsr_s, cts_s} = sync2_r;

  // Both the flip-flops of each synchroniser load ones in reset and otherwise run every cycle; logic reads only stage two.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
    end else begin
      sync1_r <= {rxd_i, cd_i, dsr_i, cts_i};
      sync2_r <= sync1_r;
    end
  end

  function automatic bit_cnt_t rate_cycles(input logic [7:0] code, input logic is_tx);
    int bps;
    bps = 1200;
    case (code)
      8'h0F: bps = 19200;
      8'h0E: bps = 9600;
      8'h0D: bps = 4800;
      8'h0C: bps = 2400;
      8'h0A: bps = 1200;
      8'h08: bps = 600;
      8'h06: bps = 300;
      8'h05: bps = 200;
      8'h04: bps = 150;
      8'h02: bps = 110;
      `RATE_SPLIT_TX75: bps = is_tx ? 75 : 1200;
      `RATE_SPLIT_RX75: bps = is_tx ? 1200 : 75;
      default: bps = 1200;
    endcase
    return bit_cnt_t'(CLK_HZ / bps);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, so ack comes on the second edge of a request.
  assign req = cyc_i & stb_i;
  assign wr_cmd = req & we_i & ack_o & (adr_i == `ADDR_CMD);
  assign fn = dat_i[7:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req & ~ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (req & ~ack_o & ~we_i) begin
      if (adr_i == `ADDR_CFG) begin
        dat_o <= cfg_r;
      end else if (adr_i == `ADDR_OPT) begin
        dat_o <= opt_r;
      end else if (adr_i == `ADDR_RESULT) begin
        dat_o <= result_r;
      end else if (adr_i == `ADDR_STATUS) begin
        dat_o <= {24'h0, status};
      end else if (adr_i == `ADDR_PTRS) begin
        dat_o <= {9'h0, count_r, 2'h0, wr_ptr_r, 2'h0, rd_ptr_r};
      end else begin
        dat_o <= 32'h0;
      end
    end
  end

  // Parameter staging; only byte lanes selected by sel_i are written.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= `RESET_CFG;
      opt_r <= `RESET_OPT;
    end else if (req & we_i & ack_o) begin
      for (int i = 0; i < 4; i++) begin
        if (sel_i[i] && adr_i == `ADDR_CFG) cfg_r[i*8 +: 8] <= dat_i[i*8 +: 8];
        if (sel_i[i] && adr_i == `ADDR_OPT) opt_r[i*8 +: 8] <= dat_i[i*8 +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (cfg_r[7:0])
      8'h0F, 8'h0E, 8'h0D, 8'h0C, 8'h0A, 8'h08, 8'h06, 8'h05, 8'h04, 8'h02,
      `RATE_SPLIT_TX75, `RATE_SPLIT_RX75: rate_ok = 1'b1;
      default: rate_ok = 1'b0;
    endcase
  end

  assign params_ok = rate_ok
    & (cfg_r[15:8] == `BITS_7 | cfg_r[15:8] == `BITS_8)
    & (cfg_r[23:16] == `PAR_NONE | cfg_r[23:16] == `PAR_ODD | cfg_r[23:16] == `PAR_EVEN)
    & (cfg_r[31:24] == `STOP_1 | cfg_r[31:24] == `STOP_2)
    & (opt_r[15:8] != 8'h0) & (opt_r[15:8] <= 8'(`BUF_DEPTH));

  assign full = count_r == len_r;
  assign avail = count_r != 7'h0;
  assign status = {~dsr_s, frm_err_r, ovr_r, par_err_r, ~cd_s, ovf_r, full, ~open_r};

  // Function dispatch: port state, line outputs and the result word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_r <= 1'b0;
      power_o <= 1'b0;
      rx_enable_o <= 1'b0;
      dtr_o <= 1'b0;
      rts_o <= 1'b0;
      rate_r <= 8'h0A;
      bits_r <= `BITS_8;
      par_r <= `PAR_NONE;
      stop_r <= `STOP_1;
      opts_r <= 8'hFF;
      len_r <= 7'(`BUF_DEPTH);
      result_r <= 32'h0;
    end else if (wr_cmd) begin
      result_r <= {24'h0, `RES_BAD_FN};
      case (fn)
        `FN_OPEN: begin
          if (open_r) begin
            result_r <= {23'h0, 1'b0, `RES_ALREADY};
          end else if (!params_ok) begin
            result_r <= {23'h0, 1'b0, `RES_BAD_PARAM};
          end else begin
            result_r <= {23'h0, 1'b1, `RES_OK};
            open_r <= 1'b1;
            power_o <= 1'b1;
            rx_enable_o <= 1'b1;
            rate_r <= cfg_r[7:0];
            bits_r <= cfg_r[15:8];
            par_r <= cfg_r[23:16];
            stop_r <= cfg_r[31:24];
            opts_r <= opt_r[7:0];
            len_r <= opt_r[14:8];
            dtr_o <= opt_r[`OPT_DTR];
            rts_o <= opt_r[`OPT_RTS];
          end
        end
        `FN_CLOSE: begin
          open_r <= 1'b0;
          power_o <= 1'b0;
          rx_enable_o <= 1'b0;
          result_r <= {23'h0, 1'b1, `RES_OK};
        end
        `FN_RX_QUERY: result_r <= {24'h0, avail ? `RES_YES : `RES_OK};
        `FN_TX_QUERY: result_r <= {24'h0, tx_ready ? `RES_YES : `RES_OK};
        `FN_RECEIVE: result_r <= {15'h0, avail, 8'h0, avail ? buf_mem[rd_ptr_r] : 8'h0};
        `FN_SEND: result_r <= {24'h0, tx_ready ? `RES_OK : `RES_BAD_FN};
        `FN_LINES_GET: result_r <= {24'h0, 4'h0, cts_s, dsr_s, cd_s, rxd_s};
        `FN_LINES_SET: begin
          dtr_o <= dat_i[8 + `OPT_DTR];
          rts_o <= dat_i[8 + `OPT_RTS];
          result_r <= {23'h0, 1'b1, `RES_OK};
        end
        `FN_ERR_CHECK: result_r <= {24'h0, status};
        `FN_OPEN_CHECK: result_r <= {24'h0, open_r ? `RES_OK : 8'h01};
        default: result_r <= {24'h0, `RES_BAD_FN};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  tx_state_t tx_state_r;
  bit_cnt_t tx_cnt_r;
  logic [3:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic tx_par_r;
  logic tx_paused_r;

  assign tx_ready = open_r & (tx_state_r == TX_IDLE) & ~tx_paused_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_r <= TX_IDLE;
      tx_cnt_r <= '0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 8'h0;
      tx_par_r <= 1'b0;
      txd_o <= 1'b1;
    end else begin
      tx_cnt_r <= tx_cnt_r - 21'd1;
      case (tx_state_r)
        TX_IDLE: begin
          txd_o <= 1'b1;
          if (wr_cmd && fn == `FN_SEND && tx_ready) begin
            tx_sh_r <= dat_i[15:8];
            tx_par_r <= (par_r == `PAR_ODD);
            tx_cnt_r <= rate_cycles(rate_r, 1'b1);
            tx_bit_r <= 4'h0;
            txd_o <= 1'b0;
            tx_state_r <= TX_START;
          end
        end
        TX_START, TX_DATA: begin
          if (tx_cnt_r == 21'd1) begin
            tx_cnt_r <= rate_cycles(rate_r, 1'b1);
            if (tx_bit_r == ((bits_r == `BITS_7) ? 4'd7 : 4'd8)) begin
              tx_state_r <= (par_r == `PAR_NONE) ? TX_STOP : TX_PAR;
              txd_o <= (par_r == `PAR_NONE) ? 1'b1 : tx_par_r;
              tx_bit_r <= 4'h0;
            end else begin
              tx_state_r <= TX_DATA;
              txd_o <= tx_sh_r[0];
              tx_par_r <= tx_par_r ^ tx_sh_r[0];
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
              tx_bit_r <= tx_bit_r + 4'd1;
            end
          end
        end
        TX_PAR: begin
          if (tx_cnt_r == 21'd1) begin
            tx_cnt_r <= rate_cycles(rate_r, 1'b1);
            txd_o <= 1'b1;
            tx_state_r <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_cnt_r == 21'd1) begin
            tx_cnt_r <= rate_cycles(rate_r, 1'b1);
            if (stop_r == `STOP_2 && tx_bit_r == 4'h0) begin
              tx_bit_r <= 4'h1;
            end else begin
              tx_state_r <= TX_IDLE;
            end
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: samples each bit in its middle, after a half-bit start check.
  rx_state_t rx_state_r;
  bit_cnt_t rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_par_r;
  logic rx_done;
  logic shift_out_r;
  logic [7:0] rx_char;

  assign rx_done = (rx_state_r == RX_STOP) && rx_cnt_r == 21'd1;
  assign rx_char = (bits_r == `BITS_7) ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r <= '0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h0;
      rx_par_r <= 1'b0;
    end else begin
      rx_cnt_r <= rx_cnt_r - 21'd1;
      case (rx_state_r)
        RX_IDLE: begin
          if (rx_enable_o && !rxd_s) begin
            rx_cnt_r <= rate_cycles(rate_r, 1'b0) >> 1;
            rx_state_r <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt_r == 21'd1) begin
            rx_cnt_r <= rate_cycles(rate_r, 1'b0);
            rx_bit_r <= 4'h0;
            rx_par_r <= (par_r == `PAR_ODD);
            rx_state_r <= rxd_s ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_cnt_r == 21'd1) begin
            rx_cnt_r <= rate_cycles(rate_r, 1'b0);
            rx_sh_r <= {rxd_s, rx_sh_r[7:1]};
            rx_par_r <= rx_par_r ^ rxd_s;
            rx_bit_r <= rx_bit_r + 4'd1;
            if (rx_bit_r == ((bits_r == `BITS_7) ? 4'd6 : 4'd7)) begin
              rx_state_r <= (par_r == `PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
        end
        RX_PAR: begin
          if (rx_cnt_r == 21'd1) begin
            rx_cnt_r <= rate_cycles(rate_r, 1'b0);
            rx_par_r <= rx_par_r ^ rxd_s;
            rx_state_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          // Only the first stop bit is checked; a second one is idle line anyway.
          if (rx_cnt_r == 21'd1) begin
            rx_state_r <= RX_IDLE;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // Flow control and shift state follow the received stream.
  always_ff @(posedge clk_i) begin
    if (rst_i || !open_r) begin
      tx_paused_r <= 1'b0;
      shift_out_r <= 1'b0;
    end else if (rx_done && rxd_s) begin
      if (!opts_r[`OPT_NO_XONXOFF] && rx_char == `CHR_XOFF) tx_paused_r <= 1'b1;
      if (!opts_r[`OPT_NO_XONXOFF] && rx_char == `CHR_XON) tx_paused_r <= 1'b0;
      if (!opts_r[`OPT_NO_SHIFT] && bits_r == `BITS_7) begin
        if (rx_char == `CHR_SO) shift_out_r <= 1'b1;
        if (rx_char == `CHR_SI) shift_out_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ring buffer. A completed character waits in a holding stage for a cycle with no delivery, so
  // that a delivery and a store never race on the count.
  logic is_ctrl;

  assign is_ctrl = (!opts_r[`OPT_NO_XONXOFF] && (rx_char == `CHR_XON || rx_char == `CHR_XOFF))
    || (!opts_r[`OPT_NO_SHIFT] && bits_r == `BITS_7
        && (rx_char == `CHR_SO || rx_char == `CHR_SI));
  assign do_pop = wr_cmd && fn == `FN_RECEIVE && avail;
  assign push = hold_v_r && !do_pop && !full;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_v_r <= 1'b0;
      hold_r <= 8'h0;
    end else begin
      if (!do_pop) hold_v_r <= 1'b0;
      if (rx_done && rxd_s && !is_ctrl) begin
        hold_v_r <= 1'b1;
        hold_r <= {shift_out_r | rx_char[7], rx_char[6:0]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) buf_mem[wr_ptr_r] <= hold_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (wr_cmd && fn == `FN_OPEN && !open_r)) begin
      rd_ptr_r <= 6'h0;
      wr_ptr_r <= 6'h0;
      count_r <= 7'h0;
    end else begin
      if (do_pop) rd_ptr_r <= (7'(rd_ptr_r) + 7'd1 == len_r) ? 6'h0 : rd_ptr_r + 6'd1;
      if (push) wr_ptr_r <= (7'(wr_ptr_r) + 7'd1 == len_r) ? 6'h0 : wr_ptr_r + 6'd1;
      if (do_pop) count_r <= count_r - 7'd1;
      else if (push) count_r <= count_r + 7'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky errors: a new event in the clearing cycle wins over the clear.
  logic clr_err;

  assign clr_err = wr_cmd && fn == `FN_ERR_CHECK;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_r <= 1'b0;
      par_err_r <= 1'b0;
      ovr_r <= 1'b0;
      frm_err_r <= 1'b0;
    end else begin
      if (clr_err) begin
        ovf_r <= 1'b0;
        par_err_r <= 1'b0;
        ovr_r <= 1'b0;
        frm_err_r <= 1'b0;
      end
      if (hold_v_r && !do_pop && full) ovf_r <= 1'b1;
      if (rx_done && par_r != `PAR_NONE && rx_par_r) par_err_r <= 1'b1;
      if (rx_done && hold_v_r && do_pop) ovr_r <= 1'b1;
      if (rx_done && !rxd_s) frm_err_r <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/serial_port_regs.svh */
// Offsets, codes, field positions and timing figures of the serial service unit.
// Assumes a 32-bit classic Wishbone slave on a 100 MHz clock.
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
`define ADDR_CMD 8'h00
`define ADDR_CFG 8'h04
`define ADDR_OPT 8'h08
`define ADDR_RESULT 8'h0C
`define ADDR_STATUS 8'h10
`define ADDR_PTRS 8'h14
`define FN_OPEN 8'h10
`define FN_CLOSE 8'h20
`define FN_RX_QUERY 8'h30
`define FN_TX_QUERY 8'h40
`define FN_RECEIVE 8'h50
`define FN_SEND 8'h60
`define FN_LINES_GET 8'h70
`define FN_LINES_SET 8'h80
`define FN_ERR_CHECK 8'h90
`define FN_OPEN_CHECK 8'hF0
`define RES_OK 8'h00
`define RES_ALREADY 8'h02
`define RES_BAD_PARAM 8'h03
`define RES_BAD_FN 8'hFF
`define RES_YES 8'hFF
`define ST_CLOSED 0
`define ST_FULL 1
`define ST_OVERFLOW 2
`define ST_CD_N 3
`define ST_PARITY 4
`define ST_OVERRUN 5
`define ST_FRAMING 6
`define ST_DSR_N 7
`define OPT_DTR 0
`define OPT_RTS 1
`define OPT_NO_SHIFT 2
`define OPT_NO_XONXOFF 4
`define BITS_7 8'h02
`define BITS_8 8'h03
`define PAR_NONE 8'h00
`define PAR_ODD 8'h01
`define PAR_EVEN 8'h03
`define STOP_1 8'h01
`define STOP_2 8'h03
`define RATE_SPLIT_TX75 8'h81
`define RATE_SPLIT_RX75 8'h80
`define CHR_XON 8'h11
`define CHR_XOFF 8'h13
`define CHR_SO 8'h0E
`define CHR_SI 8'h0F
`define BUF_DEPTH 64
`define CLK_HZ 100000000
`define RESET_CFG 32'h0000_0000
`define RESET_OPT 32'h0000_00FF
`endif

/* File: verilog/serial_port_pkg.sv */
// Types shared by the serial service unit.
// Assumes nothing beyond a SystemVerilog compiler.
package serial_port_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PAR = 5'b01000,
    RX_STOP = 5'b10000
  } rx_state_t;
  typedef logic [20:0] bit_cnt_t;
endpackage

/* File: verif/serial_port_service_unit_monitor.sv */
// Checker for the serial port service unit, bound to its top module.
// Assumes the function codes and offsets of the shared header.
`timescale 1ns/1ps
`include "serial_port_regs.svh"
`default_nettype none
module serial_port_monitor #(
  parameter int CLK_HZ = 100000000
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Link.
  input wire logic txd_o,
  input wire logic dtr_o,
  input wire logic rts_o,
  input wire logic power_o,
  input wire logic rx_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_cmd(logic [7:0] fn);
    ack_o && we_i && adr_i == `ADDR_CMD && dat_i[7:0] == fn;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_ack_follows: assert property (s_req |=> ack_o)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
    else $error("ack without request");
  chk_reset_lines: assert property ($fell(rst_i) |-> txd_o && !power_o && !dtr_o && !rts_o)
    else $error("link outputs not idle after reset");
  chk_power_pair: assert property (power_o == rx_enable_o)
    else $error("power and receive enable differ");
  chk_close_off: assert property (s_cmd(`FN_CLOSE) |=> !power_o && !rx_enable_o)
    else $error("close left power on");
  chk_lines_set: assert property (s_cmd(`FN_LINES_SET) ##0 power_o |=>
    dtr_o == $past(dat_i[8]) && rts_o == $past(dat_i[9]))
    else $error("control lines not set");
  chk_start_bit: assert property ($fell(txd_o) |-> !txd_o [*8])
    else $error("transmit bit too short");
  chk_unmapped_zero: assert property (ack_o && !we_i && adr_i >= 8'h18 |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind serial_port_service_unit serial_port_monitor #(.CLK_HZ(CLK_HZ)) i_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .txd_o(txd_o), .dtr_o(dtr_o), .rts_o(rts_o),
  .power_o(power_o), .rx_enable_o(rx_enable_o));
`default_nettype wire

/* File: verif/remote_terminal_model.sv */
// Remote terminal model: sends framed characters and decodes the transmit line.
// Assumes one stop bit sent and a bit time of BIT_CYC clocks.
`timescale 1ns/1ps
`default_nettype none
module remote_terminal_model #(
  parameter int BIT_CYC = 100
) (
  // Clock.
  input wire logic clk_i,
  // From the unit.
  input wire logic txd_i,
  // To the unit.
  output var logic rxd_o,
  output var logic cd_o,
  output var logic dsr_o,
  output var logic cts_o
);
  int nbits = 8;
  int par = 1;
  logic [8:0] got_q[$];
  logic [7:0] dc;
  logic dp;
  initial begin
    rxd_o = 1'b1;
    cd_o = 1'b1;
    dsr_o = 1'b1;
    cts_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Bit 0 of bad flips parity, bit 1 drops the stop bit.
  task automatic send(input logic [7:0] c, input logic [1:0] bad);
    logic [11:0] f;
    logic p;
    int n;
    f = '1;
    f[0] = 1'b0;
    p = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      f[i + 1] = c[i];
      p ^= c[i];
    end
    n = nbits + 1;
    if (par != 0) begin
      f[n] = p ^ (par == 1) ^ bad[0];
      n++;
    end
    f[n] = ~bad[1];
    n++;
    for (int i = 0; i < n; i++) begin
      rxd_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    repeat (BIT_CYC) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Bit 8 of a decoded entry marks a parity or stop error.
  always begin
    @(negedge txd_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    dc = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      dc[i] = txd_i;
    end
    dp = 1'b0;
    if (par != 0) begin
      repeat (BIT_CYC) @(posedge clk_i);
      dp = txd_i ^ (^dc) ^ (par == 1);
    end
    repeat (BIT_CYC) @(posedge clk_i);
    got_q.push_back({dp | ~txd_i, dc});
  end
endmodule
`default_nettype wire

/* File: verif/serial_port_service_unit_tb_top.sv */
// Testbench of the serial port service unit against a remote terminal model.
// Assumes CLK_HZ scaled so that a 19200 bps bit lasts 100 clocks.
`timescale 1ns/1ps
`include "serial_port_regs.svh"
`default_nettype none
module serial_port_service_unit_tb_top;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 8'h00, c;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, r, seed = 32'd85;
  logic ack_o, rxd_i, cd_i, dsr_i, cts_i, txd_o, dtr_o, rts_o, power_o, rx_enable_o;
  int failures = 0, num_checks = 0, n;
  logic [7:0] rx_q[$];
  serial_port_service_unit #(.CLK_HZ(1920000)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd_i), .cd_i(cd_i), .dsr_i(dsr_i), .cts_i(cts_i),
    .txd_o(txd_o), .dtr_o(dtr_o), .rts_o(rts_o), .power_o(power_o), .rx_enable_o(rx_enable_o));
  remote_terminal_model #(.BIT_CYC(100)) i_far (.clk_i(clk_i), .txd_i(txd_o),
    .rxd_o(rxd_i), .cd_o(cd_i), .dsr_o(dsr_i), .cts_o(cts_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      failures++;
    end
  endtask
  // The request is held until ack is sampled; a hang ends the run.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      failures++;
      conclude();
    end
  endtask
  task automatic cmd(input logic [7:0] fn, input logic [7:0] arg);
    wb(1'b1, `ADDR_CMD, {16'h0, arg, fn});
    wb(1'b0, `ADDR_RESULT, 32'h0);
  endtask
  // An empty queue must not pass for a zero character, so a lapsed wait fails the run.
  task automatic expect_tx(input logic [8:0] e);
    n = 0;
    while (i_far.got_q.size() == 0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      conclude();
    end
    chk("tx char", e, i_far.got_q.pop_front());
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    failures++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `ADDR_CFG, 32'h0);
    chk("cfg", `RESET_CFG, r);
    wb(1'b0, `ADDR_OPT, 32'h0);
    chk("opt", `RESET_OPT, r);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, r);
    cmd(`FN_OPEN_CHECK, 8'h00);
    chk("open check", 32'h1, r[7:0]);
    cmd(`FN_SEND, 8'h55);
    chk("send closed", 32'hFF, r[7:0]);
    cmd(8'h33, 8'h00);
    chk("bad fn", 32'hFF, r[7:0]);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    chk("status closed", 32'h1, r[0]);
    $display("test reset done");
    wb(1'b1, `ADDR_CFG, 32'h0101030F);
    wb(1'b1, `ADDR_OPT, 32'h00000017);
    cmd(`FN_OPEN, 8'h00);
    chk("open bad", 32'h003, r[8:0]);
    sel_i <= 4'h2;
    wb(1'b1, `ADDR_OPT, 32'h5A5A02A5);
    sel_i <= 4'hF;
    wb(1'b0, `ADDR_OPT, 32'h0);
    chk("opt lane", 32'h217, r);
    cmd(`FN_OPEN, 8'h00);
    chk("open ok", 32'h100, r[8:0]);
    cmd(`FN_OPEN, 8'h00);
    chk("open again", 32'h002, r[8:0]);
    chk("lines", 32'hF, {power_o, rx_enable_o, dtr_o, rts_o});
    $display("test open done");
    c = rnd();
    cmd(`FN_TX_QUERY, 8'h00);
    chk("tx ready", 32'hFF, r[7:0]);
    cmd(`FN_SEND, c);
    chk("send", 32'h0, r[7:0]);
    expect_tx({1'b0, c});
    $display("test transmit done");
    for (int k = 0; k < 3; k++) begin
      c = rnd();
      i_far.send(c, 2'b00);
      if (rx_q.size() < 2)
        rx_q.push_back(c);
    end
    wb(1'b0, `ADDR_STATUS, 32'h0);
    chk("status ovf", 32'h06, r[7:0]);
    wb(1'b0, `ADDR_PTRS, 32'h0);
    chk("ptrs full", 32'h00020000, r & 32'h007F3F3F);
    cmd(`FN_RX_QUERY, 8'h00);
    chk("rx waiting", 32'hFF, r[7:0]);
    repeat (2) begin
      cmd(`FN_RECEIVE, 8'h00);
      chk("rx char", {1'b1, rx_q.pop_front()}, {r[16], r[7:0]});
    end
    cmd(`FN_RX_QUERY, 8'h00);
    chk("rx empty", 32'h0, r[7:0]);
    wb(1'b0, `ADDR_PTRS, 32'h0);
    chk("ptrs wrap", 32'h0, r & 32'h007F3F3F);
    cmd(`FN_ERR_CHECK, 8'h00);
    chk("err ovf", 32'h04, r[7:0]);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    chk("status clr", 32'h0, r[7:0]);
    $display("test receive done");
    i_far.cd_o <= 1'b0;
    i_far.dsr_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    chk("status lines", 32'h88, r[7:0]);
    cmd(`FN_LINES_GET, 8'h00);
    chk("lines get", 32'h9, r[3:0]);
    cmd(`FN_LINES_SET, 8'h02);
    chk("lines set", 32'h1, {dtr_o, rts_o});
    i_far.cd_o <= 1'b1;
    i_far.dsr_o <= 1'b1;
    $display("test lines done");
    i_far.send(rnd(), 2'b01);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    chk("parity err", 32'h1, r[4]);
    i_far.send(rnd(), 2'b10);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    chk("framing err", 32'h1, r[6]);
    cmd(`FN_ERR_CHECK, 8'h00);
    chk("err both", 32'h3, {r[6], r[4]});
    wb(1'b0, `ADDR_STATUS, 32'h0);
    chk("err clr", 32'h0, {r[6], r[5], r[4]});
    $display("test errors done");
    cmd(`FN_CLOSE, 8'h00);
    chk("close", 32'h0, r[7:0]);
    chk("power off", 32'h0, {power_o, rx_enable_o});
    cmd(`FN_OPEN_CHECK, 8'h00);
    chk("closed", 32'h1, r[7:0]);
    $display("test close done");
    i_far.nbits = 7;
    i_far.par = 2;
    wb(1'b1, `ADDR_CFG, 32'h0303020F);
    wb(1'b1, `ADDR_OPT, 32'h00000403);
    cmd(`FN_OPEN, 8'h00);
    chk("reopen", 32'h100, r[8:0]);
    i_far.send(`CHR_XOFF, 2'b00);
    cmd(`FN_TX_QUERY, 8'h00);
    chk("paused", 32'h0, r[7:0]);
    i_far.send(`CHR_XON, 2'b00);
    cmd(`FN_TX_QUERY, 8'h00);
    chk("resumed", 32'hFF, r[7:0]);
    c = (rnd() & 8'h3F) | 8'h40;
    cmd(`FN_SEND, c);
    expect_tx({1'b0, c});
    i_far.send(`CHR_SO, 2'b00);
    i_far.send(c, 2'b00);
    cmd(`FN_RECEIVE, 8'h00);
    chk("shifted", {1'b1, 1'b1, c[6:0]}, {r[16], r[7:0]});
    $display("test seven bit done");
    conclude();
  end
endmodule
`default_nettype wire
